//--- common/acc_defs.svh
// register offsets, field positions and timing counts of the conversion control block
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH
// byte offsets on the register bus
`define ACC_OFF_SC1 4'h0
`define ACC_OFF_SC2 4'h4
`define ACC_OFF_RES 4'h8
`define ACC_OFF_CMP 4'hc
// first status/control register fields
`define ACC_SC1_DONE 7
`define ACC_SC1_IEN 6
`define ACC_SC1_CONT 5
// second control register fields
`define ACC_SC2_ACT 7
`define ACC_SC2_TRG 6
`define ACC_SC2_CFE 5
`define ACC_SC2_CGT 4
// channel codes
`define ACC_CH_OFF 5'h1f
`define ACC_CH_LAST_AIN 5'h1b
`define ACC_CH_RSVD 5'h1c
`define ACC_CH_VREFH 5'h1d
`define ACC_CH_VREFL 5'h1e
// reset values
`define ACC_SC1_RST 8'h1f
`define ACC_SC2_RST 8'h00
// conversion time, 2500 ns at a 50 ns clock period
`define ACC_CONV_NS 2500
`define ACC_CLK_NS 50
`define ACC_CONV_CYC ((`ACC_CONV_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`endif

//--- common/acc_pkg.sv
// types shared by the conversion control block
package acc_pkg;
   typedef enum logic [1:0] {ACC_OFF, ACC_IDLE, ACC_CONV} acc_state_e;
   typedef enum logic [1:0] {ACC_SRC_AIN, ACC_SRC_VREFH, ACC_SRC_VREFL, ACC_SRC_NONE} acc_src_e;
   typedef logic [9:0] acc_res_t;
endpackage : acc_pkg

//--- src/acc_ctrl.sv
// conversion control: status/control registers, sequencing, done flag and interrupt
`timescale 1ns/100ps
`include "acc_defs.svh"
module acc_ctrl #(
   parameter int CONV_CYCLES = `ACC_CONV_CYC
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // axi4-lite write address
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // hardware trigger pin and analog front end
   input wire logic hw_trigger_in,
   input wire acc_pkg::acc_res_t sar_result,
   output logic [4:0] analog_select,
   output acc_pkg::acc_src_e input_source,
   output logic converter_power,
   output logic sample_start,
   // status
   output logic conversion_active,
   output logic done_irq
);
   import acc_pkg::*;

   typedef struct packed {
      logic aw_got;
      logic [3:0] aw_addr;
      logic w_got;
      logic [7:0] w_data;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic done_flag;
      logic irq_en;
      logic cont;
      logic [4:0] chan;
      logic trig_hw;
      logic cmp_en;
      logic cmp_gt;
      acc_res_t cmp_val;
      acc_res_t result;
      acc_state_e state;
      acc_src_e src;
      logic power;
      logic start_p;
      logic irq;
      logic aw_rdy;
      logic w_rdy;
      logic ar_rdy;
      logic active;
   } acc_ctrl_s;
   acc_ctrl_s st_r;
   acc_ctrl_s st_nxt;

   logic trg_rise;
   logic tmr_done;
   logic cmp_true;
   logic wr_fire;
   logic wr_sc1;
   logic rd_fire;
   logic rd_res;

   // the conversion timer counts in 16 bits
   if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_bad_conv
      $error("acc_ctrl: CONV_CYCLES out of range");
   end

   // ***************************************************************
   // channel decode
   // ***************************************************************

   // source kind for a channel code; the reserved code isolates the input
   function automatic acc_src_e chan_src(input logic [4:0] ch);
      if (ch <= `ACC_CH_LAST_AIN) begin
         chan_src = ACC_SRC_AIN;
      end else if (ch == `ACC_CH_VREFH) begin
         chan_src = ACC_SRC_VREFH;
      end else if (ch == `ACC_CH_VREFL) begin
         chan_src = ACC_SRC_VREFL;
      end else begin
         chan_src = ACC_SRC_NONE;
      end
   endfunction : chan_src

   // ***************************************************************
   // submodules
   // ***************************************************************

   // the trigger comes from another timer block, treat it as asynchronous
   acc_sync acc_sync_inst (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .async_in(hw_trigger_in),
      .level_out(),
      .rise_out(trg_rise)
   );

   acc_timer #(.CYCLES(CONV_CYCLES)) acc_timer_inst (
      .clk(clk),
      .reset_n(reset_n),
      .clk_en(clk_en),
      .start(st_r.start_p),
      .abort(st_r.state == ACC_OFF),
      .busy(),
      .done(tmr_done)
   );

   // compare: less-than by default, greater-or-equal when selected
   assign cmp_true = st_r.cmp_gt ? (sar_result >= st_r.cmp_val) : (sar_result < st_r.cmp_val);

   assign wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
   assign wr_sc1 = wr_fire && st_r.aw_addr == `ACC_OFF_SC1 && st_r.w_lane0;
   assign rd_fire = s_axi_arvalid && !st_r.rvalid;
   assign rd_res = rd_fire && s_axi_araddr == `ACC_OFF_RES;

   // ***************************************************************
   // next state
   // ***************************************************************

   always_comb begin
      logic start_now;
      logic conv_end;
      start_now = 1'b0;
      conv_end = 1'b0;
      st_nxt = st_r;
      st_nxt.start_p = 1'b0;

      // bus: capture address and data independently, respond when both are held
      if (s_axi_awvalid && !st_r.aw_got) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_r.w_got) begin
         st_nxt.w_got = 1'b1;
         st_nxt.w_data = s_axi_wdata[7:0];
         st_nxt.w_lane0 = s_axi_wstrb[0];
      end
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end

      // register writes; only byte lane 0 carries data
      if (wr_fire) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = 2'b00;
         if (st_r.w_lane0) begin
            unique case (st_r.aw_addr)
               `ACC_OFF_SC1: begin
                  st_nxt.irq_en = st_r.w_data[`ACC_SC1_IEN];
                  st_nxt.cont = st_r.w_data[`ACC_SC1_CONT];
                  st_nxt.chan = st_r.w_data[4:0];
               end
               `ACC_OFF_SC2: begin
                  st_nxt.trig_hw = st_r.w_data[`ACC_SC2_TRG];
                  st_nxt.cmp_en = st_r.w_data[`ACC_SC2_CFE];
                  st_nxt.cmp_gt = st_r.w_data[`ACC_SC2_CGT];
               end
               `ACC_OFF_CMP: begin
                  st_nxt.cmp_val[7:0] = st_r.w_data;
               end
               `ACC_OFF_RES: begin
                  st_nxt.bresp = 2'b10; // result is read-only
               end
               default: begin
                  st_nxt.bresp = 2'b10;
               end
            endcase
         end
         if (!(st_r.aw_addr inside {`ACC_OFF_SC1, `ACC_OFF_SC2, `ACC_OFF_RES, `ACC_OFF_CMP})) begin
            st_nxt.bresp = 2'b10;
         end
      end

      // conversion sequencing
      // a done that meets a restart belongs to the aborted run, drop it
      conv_end = tmr_done && st_r.state == ACC_CONV && !st_r.start_p;
      unique case (st_r.state)
         ACC_OFF, ACC_IDLE: begin
            if (st_r.trig_hw && trg_rise && st_r.chan != `ACC_CH_OFF) begin
               start_now = 1'b1;
            end
         end
         ACC_CONV: begin
            if (conv_end) begin
               if (st_r.cont) begin
                  start_now = 1'b1;
               end else begin
                  st_nxt.state = ACC_IDLE;
                  st_nxt.power = 1'b0;
               end
            end
         end
      endcase
      if (conv_end) begin
         st_nxt.result = sar_result;
         if (!st_r.cmp_en || cmp_true) begin
            st_nxt.done_flag = 1'b1;
         end
         if (st_r.cmp_en && !cmp_true) begin
            st_nxt.result = st_r.result; // result held when compare fails
         end
      end

      // a control write aborts; restart only in software mode and channel not off
      if (wr_sc1) begin
         st_nxt.done_flag = 1'b0;
         if (st_nxt.chan == `ACC_CH_OFF) begin
            start_now = 1'b0;
            st_nxt.state = ACC_OFF;
            st_nxt.power = 1'b0;
         end else if (!st_r.trig_hw) begin
            start_now = 1'b1;
         end else begin
            start_now = 1'b0;
            st_nxt.state = ACC_IDLE;
            st_nxt.power = 1'b0;
         end
      end
      if (start_now) begin
         st_nxt.state = ACC_CONV;
         st_nxt.power = 1'b1;
         st_nxt.start_p = 1'b1;
      end
      st_nxt.src = st_nxt.state == ACC_OFF ? ACC_SRC_NONE : chan_src(st_nxt.chan);

      // register reads; a read of the low result clears the flag unless it sets now
      if (rd_fire) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = 2'b00;
         st_nxt.rdata = 32'h0000_0000;
         unique case (s_axi_araddr)
            `ACC_OFF_SC1: begin
               st_nxt.rdata[7:0] = {st_r.done_flag, st_r.irq_en, st_r.cont, st_r.chan};
            end
            `ACC_OFF_SC2: begin
               st_nxt.rdata[7:0] = {st_r.state == ACC_CONV, st_r.trig_hw, st_r.cmp_en,
                                    st_r.cmp_gt, 4'h0};
            end
            `ACC_OFF_RES: begin
               st_nxt.rdata[9:0] = st_r.result;
            end
            `ACC_OFF_CMP: begin
               st_nxt.rdata[9:0] = st_r.cmp_val;
            end
            default: begin
               st_nxt.rresp = 2'b10;
            end
         endcase
         if (rd_res && !(conv_end && (!st_r.cmp_en || cmp_true))) begin
            st_nxt.done_flag = 1'b0;
         end
      end

      // level interrupt while flag and enable are both high
      st_nxt.irq = st_nxt.done_flag && st_nxt.irq_en;

      // readies and activity kept as flops so no output passes a gate
      st_nxt.aw_rdy = !st_nxt.aw_got;
      st_nxt.w_rdy = !st_nxt.w_got;
      st_nxt.ar_rdy = !st_nxt.rvalid;
      st_nxt.active = st_nxt.state == ACC_CONV;
   end

   // ***************************************************************
   // state register
   // ***************************************************************

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_r <= '0;
         st_r.chan <= 5'(`ACC_SC1_RST);
         st_r.state <= ACC_OFF;
         st_r.src <= ACC_SRC_NONE;
         // slave free from the first edge after release
         st_r.aw_rdy <= 1'b1;
         st_r.w_rdy <= 1'b1;
         st_r.ar_rdy <= 1'b1;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state register
   assign s_axi_awready = st_r.aw_rdy;
   assign s_axi_wready = st_r.w_rdy;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = st_r.ar_rdy;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign analog_select = st_r.chan;
   assign input_source = st_r.src;
   assign converter_power = st_r.power;
   assign sample_start = st_r.start_p;
   assign conversion_active = st_r.active;
   assign done_irq = st_r.irq;
endmodule : acc_ctrl

//--- src/acc_sync.sv
// three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/100ps
module acc_sync (
   // clocking
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // pin side
   input wire logic async_in,
   // synchronous side
   output logic level_out,
   output logic rise_out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic rise;
   } acc_sync_s;
   acc_sync_s st_r;
   acc_sync_s st_nxt;

   // a change counts only once the second and third stages agree
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = async_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.rise = 1'b0;
      if (st_r.s2 == st_r.s3) begin
         st_nxt.lvl = st_r.s3;
         st_nxt.rise = st_r.s3 & ~st_r.lvl;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_r <= '0;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   assign level_out = st_r.lvl;
   assign rise_out = st_r.rise;
endmodule : acc_sync

//--- src/acc_timer.sv
// conversion timer: counts a fixed number of cycles after a start
`timescale 1ns/100ps
module acc_timer #(
   parameter int CYCLES = 50
) (
   // clocking
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // control
   input wire logic start,
   input wire logic abort,
   // status
   output logic busy,
   output logic done
);
   typedef struct packed {
      logic [15:0] cnt;
      logic busy;
      logic done;
   } acc_timer_s;
   acc_timer_s st_r;
   acc_timer_s st_nxt;

   // the count register is 16 bits wide, refuse anything it cannot hold
   if (CYCLES < 1 || CYCLES > 65535) begin : g_bad_cycles
      $error("acc_timer: CYCLES out of range");
   end

   // a start restarts the count even when busy, so an abort-and-restart is one pulse
   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      if (start) begin
         st_nxt.busy = 1'b1;
         st_nxt.cnt = 16'(CYCLES - 1);
      end else if (abort) begin
         st_nxt.busy = 1'b0;
      end else if (st_r.busy) begin
         if (st_r.cnt == 16'h0000) begin
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt - 16'h0001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_r <= '0;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   assign busy = st_r.busy;
   assign done = st_r.done;
endmodule : acc_timer

//--- tb/acc_ctrl_bench.sv
// self-checking bench of the conversion control block
`timescale 1ns/100ps
module acc_ctrl_bench;
   import acc_pkg::*;
   // ****************
   // stimulus and wiring
   // ****************
   localparam int CONV = 8;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] awaddr = 4'h0;
   logic [3:0] araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic hw = 1'b0;
   logic en = 1'b1;
   acc_res_t sar = 10'h0;
   logic awready, wready, bvalid, arready, rvalid, power, start, active, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, got;
   logic [4:0] sel;
   acc_src_e src;
   int err_total = 0;
   int checked = 0;
   int starts = 0;
   always #25 clk = ~clk;
   // count conversion starts for the one-per-trigger checks
   always @(posedge clk) if (start === 1'b1) starts <= starts + 1;
   acc_ctrl #(.CONV_CYCLES(CONV)) acc_ctrl_inst (.clk(clk), .reset_n(reset_n), .clk_en(en),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .hw_trigger_in(hw), .sar_result(sar), .analog_select(sel), .input_source(src),
      .converter_power(power), .sample_start(start), .conversion_active(active),
      .done_irq(irq));
   // ****************
   // tasks
   // ****************
   task close_out;
      $display("mismatches %0d comparisons %0d", err_total, checked);
      if (err_total == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : close_out
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task hang;
      err_total++;
      close_out();
   endtask : hang
   // master holds each channel until its own ready edge
   task wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (n == 50) hang();
      bready <= 1'b0;
      chk(bresp, er);
   endtask : wr
   task rd(input logic [3:0] a, input logic [31:0] e);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (n == 50) hang();
      got = rdata;
      rready <= 1'b0;
      chk(rresp, 2'b00);
      chk(got, e);
   endtask : rd
   task idle(input int n);
      repeat (n) @(posedge clk);
   endtask : idle
   task pulse;
      @(posedge clk);
      hw <= 1'b1;
      idle(8);
      hw <= 1'b0;
   endtask : pulse
   function automatic acc_src_e src_of(input int c);
      if (c <= 27) return ACC_SRC_AIN;
      if (c == 29) return ACC_SRC_VREFH;
      if (c == 30) return ACC_SRC_VREFL;
      return ACC_SRC_NONE;
   endfunction : src_of
   // ****************
   // scenarios
   // ****************
   task t_reset;
      rd(4'h0, 32'h1f);
      rd(4'h4, 32'h0);
      chk(power, 1'b0);
      chk(src, ACC_SRC_NONE);
   endtask : t_reset
   task t_single;
      int s0;
      sar <= 10'h2a5;
      s0 = starts;
      wr(4'h0, 8'h43, 2'b00);
      chk(active, 1'b1);
      chk(power, 1'b1);
      idle(30);
      chk(starts - s0, 1);
      chk(power, 1'b0);
      chk(irq, 1'b1);
      rd(4'h0, 32'hc3);
      rd(4'h8, 32'h2a5);
      rd(4'h0, 32'h43);
      chk(irq, 1'b0);
      wr(4'h0, 8'h43, 2'b00);
      idle(30);
      s0 = starts;
      wr(4'h0, 8'h5f, 2'b00);
      rd(4'h0, 32'h5f);
      chk(irq, 1'b0);
      idle(20);
      chk(starts, s0);
   endtask : t_single
   task t_abort;
      int s0;
      s0 = starts;
      wr(4'h0, 8'h04, 2'b00);
      wr(4'h0, 8'h05, 2'b00);
      idle(30);
      chk(starts - s0, 2);
      rd(4'h0, 32'h85);
   endtask : t_abort
   task t_cont;
      int s0;
      s0 = starts;
      wr(4'h0, 8'h21, 2'b00);
      idle(60);
      chk(starts - s0 >= 3, 1'b1);
      wr(4'h0, 8'h3f, 2'b00);
      s0 = starts;
      idle(30);
      chk(starts, s0);
      chk(power, 1'b0);
   endtask : t_cont
   task t_hw;
      int s0;
      wr(4'h4, 8'h40, 2'b00);
      s0 = starts;
      wr(4'h0, 8'h06, 2'b00);
      idle(20);
      chk(starts, s0);
      pulse();
      idle(30);
      chk(starts - s0, 1);
      wr(4'h0, 8'h26, 2'b00);
      s0 = starts;
      pulse();
      idle(60);
      chk(starts - s0 >= 3, 1'b1);
      wr(4'h0, 8'h1f, 2'b00);
      wr(4'h4, 8'h00, 2'b00);
   endtask : t_hw
   task t_cmp;
      wr(4'hc, 8'h10, 2'b00);
      wr(4'h4, 8'h20, 2'b00);
      rd(4'h4, 32'h20);
      sar <= 10'h3ff;
      wr(4'h0, 8'h01, 2'b00);
      idle(30);
      rd(4'h0, 32'h01);
      sar <= 10'h005;
      wr(4'h0, 8'h01, 2'b00);
      idle(30);
      rd(4'h0, 32'h81);
      chk(irq, 1'b0);
      wr(4'h4, 8'h30, 2'b00);
      sar <= 10'h3ff;
      wr(4'h0, 8'h01, 2'b00);
      idle(30);
      rd(4'h0, 32'h81);
      rd(4'h8, 32'h3ff);
      wr(4'h4, 8'h00, 2'b00);
      wr(4'h8, 8'h00, 2'b10);
   endtask : t_cmp
   // clock enable low must freeze a running conversion
   task t_freeze;
      wr(4'h0, 8'h02, 2'b00);
      en <= 1'b0;
      idle(40);
      chk(active, 1'b1);
      chk(power, 1'b1);
      en <= 1'b1;
      idle(30);
      rd(4'h0, 32'h82);
   endtask : t_freeze
   task t_map;
      int c;
      for (c = 0; c < 31; c++) begin
         wr(4'h0, c[7:0], 2'b00);
         idle(2);
         chk(sel, c);
         chk(src, src_of(c));
      end
      wr(4'h0, 8'h1f, 2'b00);
   endtask : t_map
   // main sequence, reset held for sixteen cycles
   initial begin
      idle(16);
      reset_n <= 1'b1;
      t_reset();
      t_single();
      t_abort();
      t_cont();
      t_hw();
      t_cmp();
      t_freeze();
      t_map();
      close_out();
   end
endmodule : acc_ctrl_bench

//--- tb/acc_ctrl_checker.sv
// port assertions of the conversion control block
`timescale 1ns/100ps
module acc_ctrl_checker #(
   parameter int CONV_CYCLES = 8
) (
   // clocking
   input wire logic clk,
   input wire logic reset_n,
   // bus answers
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   // converter side
   input wire logic [4:0] analog_select,
   input wire acc_pkg::acc_src_e input_source,
   input wire logic converter_power,
   input wire logic sample_start,
   input wire logic conversion_active,
   input wire logic done_irq
);
   import acc_pkg::*;
   // ****************
   // checks
   // ****************
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // decode checks wait one settled cycle, select and source are separate flops
   a_start_active: assert property (sample_start |-> ##[0:1] conversion_active)
      else $error("active missing after start");
   a_off_quiet: assert property (
      analog_select == 5'h1f && $stable(analog_select) |-> !converter_power && !sample_start)
      else $error("converter runs while off");
   a_src_ain: assert property (
      $stable(analog_select) && analog_select <= 5'h1b |-> input_source == ACC_SRC_AIN)
      else $error("analog input not routed");
   a_src_high: assert property (
      $stable(analog_select) && analog_select == 5'h1d |-> input_source == ACC_SRC_VREFH)
      else $error("high reference not routed");
   a_src_low: assert property (
      $stable(analog_select) && analog_select == 5'h1e |-> input_source == ACC_SRC_VREFL)
      else $error("low reference not routed");
   a_src_none: assert property (
      $stable(analog_select) && analog_select[4:2] == 3'h7
      && analog_select[1:0] inside {2'h0, 2'h3} |-> input_source == ACC_SRC_NONE)
      else $error("input not isolated");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_irq_after_conv: assert property (
      $rose(done_irq) |-> $past(conversion_active) || $past(conversion_active, 2))
      else $error("interrupt without conversion");
endmodule : acc_ctrl_checker

bind acc_ctrl acc_ctrl_checker #(.CONV_CYCLES(CONV_CYCLES)) acc_ctrl_checker_inst (
   .clk(clk),
   .reset_n(reset_n),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_bresp(s_axi_bresp),
   .analog_select(analog_select),
   .input_source(input_source),
   .converter_power(converter_power),
   .sample_start(sample_start),
   .conversion_active(conversion_active),
   .done_irq(done_irq)
);
